// ### sps_defs.svh
// constants for the scan pin sharing block
// assumes inclusion by bare name from the package and the pin sharing module
`ifndef SPS_DEFS_SVH
`define SPS_DEFS_SVH

// =====================================================================
// widths and codes
`define SPS_IR_W        4
`define SPS_DR_W        8
`define SPS_PINS        3
`define SPS_IR_CAPTURE  4'h1
`define SPS_IR_RESET    4'hF
`define SPS_IR_BYPASS   4'hF
`define SPS_IR_USER     4'h2
`define SPS_DR_RESET    8'h00
`define SPS_TLR_TMS_CNT 5

// =====================================================================
// pin indices of the shared group
`define SPS_PIN_TCK 0
`define SPS_PIN_TDI 1
`define SPS_PIN_TDO 2

`endif

// ### sps_pkg.sv
// types shared by the scan pin sharing block
// assumes sps_defs.svh is found on the include path
`include "sps_defs.svh"

package sps_pkg;

  // gray steps along the usual capture/shift/update walk, except SPS_EX1_DR to SPS_UPD_DR
  typedef enum logic [3:0] {
    SPS_TLR      = 4'h0,
    SPS_RTI      = 4'h1,
    SPS_SEL_DR   = 4'h3,
    SPS_CAP_DR   = 4'h2,
    SPS_SHIFT_DR = 4'h6,
    SPS_EX1_DR   = 4'h7,
    SPS_PAUSE_DR = 4'h5,
    SPS_EX2_DR   = 4'h4,
    SPS_UPD_DR   = 4'hC,
    SPS_SEL_IR   = 4'hD,
    SPS_CAP_IR   = 4'hF,
    SPS_SHIFT_IR = 4'hE,
    SPS_EX1_IR   = 4'hA,
    SPS_PAUSE_IR = 4'hB,
    SPS_EX2_IR   = 4'h9,
    SPS_UPD_IR   = 4'h8
  } sps_tap_state_t;

endpackage

// ### sps_tap_fsm.sv
// scan state machine of the shared scan port
// assumes tck_i is the tester's clock and rst_i is already synchronous to it
`timescale 1ns/1ps
`default_nettype none

module sps_tap_fsm
  import sps_pkg::*;
(
  input  wire logic          tck_i,
  input  wire logic          rst_i,
  input  wire logic          tms_i,
  output var sps_tap_state_t state_o,
  output var sps_tap_state_t state_d_o
);

  sps_tap_state_t state_q;
  sps_tap_state_t state_d;

  always_comb begin
    case (state_q)
      SPS_TLR:      state_d = tms_i ? SPS_TLR    : SPS_RTI;
      SPS_RTI:      state_d = tms_i ? SPS_SEL_DR : SPS_RTI;
      SPS_SEL_DR:   state_d = tms_i ? SPS_SEL_IR : SPS_CAP_DR;
      SPS_CAP_DR:   state_d = tms_i ? SPS_EX1_DR : SPS_SHIFT_DR;
      SPS_SHIFT_DR: state_d = tms_i ? SPS_EX1_DR : SPS_SHIFT_DR;
      SPS_EX1_DR:   state_d = tms_i ? SPS_UPD_DR : SPS_PAUSE_DR;
      SPS_PAUSE_DR: state_d = tms_i ? SPS_EX2_DR : SPS_PAUSE_DR;
      SPS_EX2_DR:   state_d = tms_i ? SPS_UPD_DR : SPS_SHIFT_DR;
      SPS_UPD_DR:   state_d = tms_i ? SPS_SEL_DR : SPS_RTI;
      SPS_SEL_IR:   state_d = tms_i ? SPS_TLR    : SPS_CAP_IR;
      SPS_CAP_IR:   state_d = tms_i ? SPS_EX1_IR : SPS_SHIFT_IR;
      SPS_SHIFT_IR: state_d = tms_i ? SPS_EX1_IR : SPS_SHIFT_IR;
      SPS_EX1_IR:   state_d = tms_i ? SPS_UPD_IR : SPS_PAUSE_IR;
      SPS_PAUSE_IR: state_d = tms_i ? SPS_EX2_IR : SPS_PAUSE_IR;
      SPS_EX2_IR:   state_d = tms_i ? SPS_UPD_IR : SPS_SHIFT_IR;
      SPS_UPD_IR:   state_d = tms_i ? SPS_SEL_DR : SPS_RTI;
      default:      state_d = SPS_TLR;
    endcase
  end

  always_ff @(posedge tck_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= SPS_TLR;
    end else begin
      state_q <= state_d;
    end
  end

  assign state_o   = state_q;
  assign state_d_o = state_d;

  // =====================================================================
  // checks
  tms_five_tlr_a: assert property (@(posedge tck_i) disable iff (rst_i)
    tms_i [*5] |=> (state_q == SPS_TLR))
    else $error("five high mode selects did not reach logic reset");

endmodule

`default_nettype wire

// ### sps_pin_share.sv
// shares the three scan pins between the scan port and user I/O
// assumes pins arrive unsynchronised; usr_* come from logic on clk_i
`timescale 1ns/1ps
`default_nettype none
`include "sps_defs.svh"

module sps_pin_share
  import sps_pkg::*;
#(
  parameter bit RESERVE_SCAN = 1'b0
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 tck_i,
  input  wire logic                 tms_i,
  input  wire logic                 tdi_i,
  input  wire logic [`SPS_PINS-1:0] pin_in_i,
  input  wire logic [`SPS_PINS-1:0] usr_out_i,
  input  wire logic [`SPS_PINS-1:0] usr_oe_i,
  output logic                      scan_tdo_o,
  output logic                      scan_tdo_oe_o,
  output logic [`SPS_PINS-1:0]      pin_out_o,
  output logic [`SPS_PINS-1:0]      pin_oe_o,
  output logic [`SPS_PINS-1:0]      usr_in_o,
  output logic                      scan_active_o
);

  // =====================================================================
  // reset for the test clock domain
  // stays asserted while the tester's clock stands still
  logic [1:0] rst_tck_q;
  wire        rst_tck = rst_tck_q[1];

  always_ff @(posedge tck_i or posedge rst_i) begin
    if (rst_i) begin
      rst_tck_q <= 2'h3;
    end else begin
      rst_tck_q <= {rst_tck_q[0], 1'b0};
    end
  end

  // =====================================================================
  // scan state machine and registers
  sps_tap_state_t tap_state;
  sps_tap_state_t tap_state_d;

  sps_tap_fsm u_tap (
    .tck_i     (tck_i),
    .rst_i     (rst_tck),
    .tms_i     (tms_i),
    .state_o   (tap_state),
    .state_d_o (tap_state_d)
  );

  logic                 active_q;
  logic [`SPS_IR_W-1:0] ir_q;
  logic [`SPS_IR_W-1:0] ir_sh_q;
  logic [`SPS_DR_W-1:0] dr_sh_q;
  logic [`SPS_DR_W-1:0] user_q;
  logic                 byp_q;
  logic                 tdo_q;
  logic                 tdo_oe_q;

  wire sel_user  = (ir_q == `SPS_IR_USER);
  wire in_tlr    = (tap_state == SPS_TLR);
  wire shift_ir  = (tap_state == SPS_SHIFT_IR);
  wire shift_dr  = (tap_state == SPS_SHIFT_DR);
  wire cap_ir    = (tap_state == SPS_CAP_IR);
  wire cap_dr    = (tap_state == SPS_CAP_DR);
  wire upd_ir    = (tap_state == SPS_UPD_IR);
  wire upd_dr    = (tap_state == SPS_UPD_DR);
  wire dr_lsb    = sel_user ? dr_sh_q[0] : byp_q;
  wire tdo_src   = shift_ir ? ir_sh_q[0] : dr_lsb;
  // flexible mode: in use exactly while the machine is away from reset
  wire active_d  = RESERVE_SCAN | (tap_state_d != SPS_TLR);

  always_ff @(posedge tck_i or posedge rst_tck) begin
    if (rst_tck) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active_d;
    end
  end

  always_ff @(posedge tck_i or posedge rst_tck) begin
    if (rst_tck) begin
      ir_sh_q <= `SPS_IR_RESET;
      ir_q    <= `SPS_IR_RESET;
    end else begin
      if (cap_ir) begin
        ir_sh_q <= `SPS_IR_CAPTURE;
      end else if (shift_ir) begin
        ir_sh_q <= {tdi_i, ir_sh_q[`SPS_IR_W-1:1]};
      end
      if (in_tlr) begin
        ir_q <= `SPS_IR_RESET;
      end else if (upd_ir) begin
        ir_q <= ir_sh_q;
      end
    end
  end

  always_ff @(posedge tck_i or posedge rst_tck) begin
    if (rst_tck) begin
      dr_sh_q <= `SPS_DR_RESET;
      byp_q   <= 1'b0;
      user_q  <= `SPS_DR_RESET;
    end else begin
      if (cap_dr) begin
        dr_sh_q <= user_q;
        byp_q   <= 1'b0;
      end else if (shift_dr) begin
        dr_sh_q <= {tdi_i, dr_sh_q[`SPS_DR_W-1:1]};
        byp_q   <= tdi_i;
      end
      if (upd_dr && sel_user) begin
        user_q <= dr_sh_q;
      end
    end
  end

  // falling edge gives the tester half a period of hold
  always_ff @(negedge tck_i or posedge rst_tck) begin
    if (rst_tck) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q    <= tdo_src;
      tdo_oe_q <= active_q;
    end
  end

  assign scan_tdo_o    = tdo_q;
  assign scan_tdo_oe_o = tdo_oe_q;

  // =====================================================================
  // system clock side: user I/O on the shared pins
  logic [1:0]           act_sync_q;
  logic [`SPS_PINS-1:0] pin_out_q;
  logic [`SPS_PINS-1:0] pin_oe_q;

  // limitation: scan drive starts at the tck fall, user drive stops 2-3 clk after the tck rise before it;
  // the tester must not rely on the pad until the claim has crossed over
  wire user_owns = ~act_sync_q[1] & ~RESERVE_SCAN;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_sync_q <= 2'h0;
    end else begin
      act_sync_q <= {act_sync_q[0], active_q};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `SPS_PINS; gi = gi + 1) begin : g_pin
      logic [1:0] in_sync_q;

      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          in_sync_q     <= 2'h0;
          pin_out_q[gi] <= 1'b0;
          pin_oe_q[gi]  <= 1'b0;
        end else begin
          in_sync_q     <= {in_sync_q[0], pin_in_i[gi]};
          pin_out_q[gi] <= usr_out_i[gi];
          pin_oe_q[gi]  <= usr_oe_i[gi] & user_owns;
        end
      end

      assign usr_in_o[gi] = in_sync_q[1];
    end
  endgenerate

  assign pin_out_o     = pin_out_q;
  assign pin_oe_o      = pin_oe_q;
  assign scan_active_o = act_sync_q[1];

  // =====================================================================
  // checks
  claim_low_tms_a: assert property (@(posedge tck_i) disable iff (rst_tck)
    (in_tlr && !tms_i) |=> active_q)
    else $error("low mode select did not claim the scan pins");

  hold_until_tlr_a: assert property (@(posedge tck_i) disable iff (rst_tck)
    (active_q && tap_state_d != SPS_TLR) |=> active_q)
    else $error("scan use dropped before logic reset");

  release_tlr_a: assert property (@(posedge tck_i) disable iff (rst_tck)
    (!RESERVE_SCAN && tap_state_d == SPS_TLR) |=> !active_q)
    else $error("scan pins not released at logic reset");

  dedicated_on_a: assert property (@(posedge tck_i) disable iff (rst_tck)
    (RESERVE_SCAN && !rst_tck) |=> active_q)
    else $error("dedicated mode left scan use");

  tdi_shift_a: assert property (@(posedge tck_i) disable iff (rst_tck)
    (shift_dr && sel_user) |=> (dr_sh_q[`SPS_DR_W-1] == $past(tdi_i)))
    else $error("test data input bit not shifted in");

  tdo_drive_a: assert property (@(negedge tck_i) disable iff (rst_tck)
    active_q |=> (tdo_oe_q && tdo_q == $past(tdo_src)))
    else $error("test data output not driven during scan use");

  user_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (act_sync_q[1] || RESERVE_SCAN) |=> (pin_oe_q == '0))
    else $error("user drive on shared pins during scan use");

  ir_capture_a: assert property (@(posedge tck_i) disable iff (rst_tck)
    cap_ir |=> (ir_sh_q == `SPS_IR_CAPTURE))
    else $error("instruction capture value not loaded");

  tdo_release_a: assert property (@(negedge tck_i) disable iff (rst_tck)
    !active_q |=> !tdo_oe_q)
    else $error("test data output still driven after release");

  cv_claim_c: cover property (@(posedge tck_i) disable iff (rst_tck)
    !active_q ##1 active_q);
  cv_release_c: cover property (@(posedge tck_i) disable iff (rst_tck)
    active_q ##1 !active_q);
  cv_user_upd_c: cover property (@(posedge tck_i) disable iff (rst_tck)
    upd_dr && sel_user);
  cv_ir_load_c: cover property (@(posedge tck_i) disable iff (rst_tck)
    upd_ir && ir_sh_q == `SPS_IR_USER);

endmodule

`default_nettype wire

// ### sps_scan_tester.sv
// model of the external scan tester on the far side of the shared pins
// assumes the bench calls tick(); the test clock idles low between calls
`timescale 1ns/1ps
`default_nettype none

module sps_scan_tester (
  output var logic tck_o,
  output var logic tms_o,
  output var logic tdi_o,
  input  wire logic tdo_i
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // =====================================================
  // one 48 ns test clock cycle, result taken at the rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #24 tck_o = 1'b1;
    tdo = tdo_i;
    #24 tck_o = 1'b0;
    // data is not held after the cycle, so a stale bit cannot pass
    tdi_o = ~tdi;
  endtask
endmodule

`default_nettype wire

// ### sps_pin_share_tb.sv
// self-checking bench for the shared scan pins, flexible and dedicated builds
// assumes the scan tester model drives the test clock pins
`timescale 1ns/1ps
`default_nettype none

module sps_pin_share_tb;
  import sps_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [2:0] usr_out, usr_oe, ext_lvl, pout_f, poe_f, uin_f, poe_d;
  logic       tck, tms, tdi, pad2, tdo_f, oe_f, act_f, act_d, b;
  int         mismatches = 0;
  int         total_checks = 0;

  always #12.5 clk_i = ~clk_i;
  // tdo pad: scan driver first, then user driver, else outside level
  assign pad2 = oe_f ? tdo_f : (poe_f[2] ? pout_f[2] : ext_lvl[2]);

  sps_pin_share u_sps_pin_share (
    .clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .pin_in_i({pad2, ext_lvl[1:0]}), .usr_out_i(usr_out), .usr_oe_i(usr_oe),
    .scan_tdo_o(tdo_f), .scan_tdo_oe_o(oe_f), .pin_out_o(pout_f),
    .pin_oe_o(poe_f), .usr_in_o(uin_f), .scan_active_o(act_f));
  sps_pin_share #(.RESERVE_SCAN(1'b1)) u_sps_pin_share_ded (
    .clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .pin_in_i(ext_lvl), .usr_out_i(usr_out), .usr_oe_i(usr_oe),
    .scan_tdo_o(), .scan_tdo_oe_o(), .pin_out_o(), .pin_oe_o(poe_d),
    .usr_in_o(), .scan_active_o(act_d));
  sps_scan_tester u_sps_scan_tester (
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_f));

  // =====================================================
  // checking and closing
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // bounded wait for the synced scan flag of the flexible build
  task automatic wait_act(input logic v);
    for (int i = 0; i < 20; i++) begin
      @(negedge clk_i);
      if (act_f === v) return;
    end
    mismatches++;
    $display("[FAIL] %0t ns: scan flag wait ran out", $time);
    tally_and_finish();
  endtask

  // =====================================================
  // scenarios
  task automatic t_user();
    @(negedge clk_i);
    usr_oe  = 3'b100;
    usr_out = 3'b000;
    ext_lvl = 3'b111;
    repeat (4) @(negedge clk_i);
    chk(poe_f, 3'b100);
    chk(uin_f, 3'b011);
    chk(act_f, 1'b0);
    chk(act_d, 1'b1);
    chk(poe_d, 3'b000);
  endtask

  task automatic t_claim();
    u_sps_scan_tester.tick(1'b0, 1'b0, b);
    wait_act(1'b1);
    repeat (2) @(negedge clk_i);
    chk(poe_f, 3'b000);
    chk(oe_f, 1'b1);
  endtask

  // bypass path: captured 0 first, then each data bit one cycle late
  task automatic t_shift();
    logic [8:0] pat;
    logic [8:0] got;
    pat = 9'h0A5;
    u_sps_scan_tester.tick(1'b1, 1'b0, b);
    u_sps_scan_tester.tick(1'b0, 1'b0, b);
    u_sps_scan_tester.tick(1'b0, 1'b0, b);
    for (int i = 0; i < 9; i++) begin
      u_sps_scan_tester.tick(1'b0, pat[i], b);
      got[i] = b;
    end
    chk(got[0], 1'b0);
    chk(got[8:1], pat[7:0]);
  endtask

  task automatic t_release();
    for (int i = 0; i < 4; i++) begin
      u_sps_scan_tester.tick(1'b1, 1'b0, b);
    end
    repeat (5) @(negedge clk_i);
    chk(act_f, 1'b1);
    chk(oe_f, 1'b1);
    chk(poe_f, 3'b000);
    u_sps_scan_tester.tick(1'b1, 1'b0, b);
    // oe is launched by the fall that ends the tick, so look after the sync wait
    wait_act(1'b0);
    chk(oe_f, 1'b0);
    repeat (2) @(negedge clk_i);
    chk(poe_f, 3'b100);
    chk(act_d, 1'b1);
  endtask

  // steps the scan state machine along tms values, lsb first, tdi low
  task automatic tms_walk(input int n, input logic [7:0] tms_seq);
    logic bit_o;
    for (int i = 0; i < n; i++) begin
      u_sps_scan_tester.tick(tms_seq[i], 1'b0, bit_o);
    end
  endtask

  // shifts n bits lsb first, leaving the shift state on the last one
  task automatic shift_bits(input int n, input logic [7:0] din, output logic [7:0] dout);
    logic bit_o;
    dout = 8'h00;
    for (int i = 0; i < n; i++) begin
      u_sps_scan_tester.tick(i == n - 1, din[i], bit_o);
      dout[i] = bit_o;
    end
  endtask

  // user register: load its instruction, write a pattern, read it back
  task automatic t_user_reg();
    logic [7:0] got;
    tms_walk(5, 8'h06);
    shift_bits(4, 8'h02, got);
    chk(got, 8'h01);
    tms_walk(2, 8'h01);
    tms_walk(3, 8'h01);
    shift_bits(8, 8'h3C, got);
    chk(got, 8'h00);
    tms_walk(2, 8'h01);
    tms_walk(3, 8'h01);
    shift_bits(8, 8'h00, got);
    chk(got, 8'h3C);
    tms_walk(4, 8'h0F);
    wait_act(1'b0);
    chk(oe_f, 1'b0);
    repeat (2) @(negedge clk_i);
    chk(poe_f, 3'b100);
  endtask

  initial begin
    usr_out = 3'b000;
    usr_oe  = 3'b000;
    ext_lvl = 3'b000;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    // two test clocks let the scan domain leave reset, a third lets the
    // dedicated build take the pins
    u_sps_scan_tester.tick(1'b1, 1'b0, b);
    u_sps_scan_tester.tick(1'b1, 1'b0, b);
    u_sps_scan_tester.tick(1'b1, 1'b0, b);
    t_user();
    t_claim();
    t_shift();
    t_release();
    t_user_reg();
    tally_and_finish();
  end
endmodule

`default_nettype wire
